// file: staging_pkg.sv
// Purpose: Constants and types shared by the motor staging controller.
// Assumes: 40 MHz clock; frequencies are whole hertz, delays whole ms.
// Notes: Offsets are byte addresses of 32-bit words.
package staging_pkg;
  localparam int unsigned CLOCK_HZ = 40_000_000;
  localparam int unsigned DELAY_TICK_US = 1000;
  localparam int unsigned DELAY_TICK_CYCLES = CLOCK_HZ / 1_000_000 * DELAY_TICK_US;
  localparam logic [8:0] HYST_HZ = 9'h001;
  localparam logic [5:0] STAGING_CODE = 6'h1d;

  localparam logic [5:0] CTRL_OFS = 6'h00;
  localparam logic [5:0] RELAY_SEL_OFS = 6'h04;
  localparam logic [5:0] ON_THR_OFS = 6'h08;
  localparam logic [5:0] OFF_THR_OFS = 6'h0c;
  localparam logic [5:0] ON_DELAY_OFS = 6'h10;
  localparam logic [5:0] OFF_DELAY_OFS = 6'h14;
  localparam logic [5:0] REF_STEP_OFS = 6'h18;
  localparam logic [5:0] STATUS_OFS = 6'h1c;
  localparam logic [5:0] FREQ_OFS = 6'h20;

  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned CTRL_ROTATE_BIT = 1;
  localparam int unsigned CTRL_COUNT_LSB = 2;
  localparam int unsigned CTRL_ORDER_LSB = 4;
  localparam int unsigned RELAY_TWO_LSB = 8;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] RELAY_SEL_RESET = 32'h0000_1d1d;
  localparam logic [31:0] ON_THR_RESET = 32'h0030_3030;
  localparam logic [31:0] OFF_THR_RESET = 32'h0019_1919;
  localparam logic [31:0] DELAY_RESET = 32'h0000_0bb8;
  localparam logic [31:0] REF_STEP_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {IDLE, ON_WAIT, OFF_WAIT} stage_state_type;
endpackage

// file: pump_fan_staging.sv
// Purpose: Stages up to three constant-speed helper motors beside a drive.
// Assumes: drive_freq is synchronous to clock; Avalon-MM slave, one wait.
// Notes: Motor rotation only permutes relays; its timing lives elsewhere.
`timescale 1ns/1ps

// Overview of operation
// - one or more running adds step one
// - two or more running adds step two
// - three running adds step three
// - none running, above start one+1 arms delay
// - after delay, above start one-1 starts motor
// - then shift frequency down start minus low
// - same start sequence for stage two
// - same start sequence for stage three
// - one running, below low one-1 arms delay
// - after delay below low+1 stop, shift up
// - same stop sequence for stage two
// - same stop sequence for stage three
// - one start delay, one stop delay shared
// - helper count limits stages and relays used
// - builtin relay stages only with staging code
// - no rotation: first staging relay drives regulated
// - rotation reassigns motors over staging relays
// - builtin, then node five, then node six
// - relays needed equal helper count plus one
// - missing expansion module raises link fault if its relays are needed
module pump_fan_staging #(
  parameter int unsigned TICK_CYCLES = staging_pkg::DELAY_TICK_CYCLES
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [7:0] drive_freq,
  input wire logic [1:0] expansion_present,
  input wire logic relay_one_other,
  input wire logic relay_two_other,
  output logic builtin_relay_one,
  output logic builtin_relay_two,
  output logic [3:0] expansion_relay,
  output logic signed [8:0] freq_shift,
  output logic freq_shift_valid,
  output logic [9:0] ref_step_total,
  output logic expansion_link_fault
);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Bus slave state
  logic ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] ctrl_q, ctrl_d, sel_q, sel_d, on_thr_q, on_thr_d, off_thr_q, off_thr_d;
  logic [31:0] on_dly_q, on_dly_d, off_dly_q, off_dly_d, step_q, step_d;
  logic [31:0] status;

  // Staging state
  staging_pkg::stage_state_type state_q, state_d;
  logic [1:0] running_q, running_d;
  logic [15:0] delay_q, delay_d, tick_q, tick_d;
  logic tick;
  logic signed [8:0] shift_q, shift_d;
  logic shift_valid_q, shift_valid_d;
  logic [9:0] ref_q, ref_d;

  // Relay state
  logic relay1_q, relay1_d, relay2_q, relay2_d, fault_q, fault_d;
  logic [3:0] exp_q, exp_d;

  logic enable, rotate, sel1, sel2, fault_now, stage_on;
  logic [1:0] count_cfg, order;
  logic [7:0] up_on, up_off, dn_on, dn_off;
  logic [1:0] dn_idx;
  logic [8:0] freq9;
  logic above_arm, above_keep, below_arm, below_keep;
  logic [3:0] logical_on, phys_on;

  assign enable = ctrl_q[staging_pkg::CTRL_ENABLE_BIT];
  assign rotate = ctrl_q[staging_pkg::CTRL_ROTATE_BIT];
  assign count_cfg = ctrl_q[staging_pkg::CTRL_COUNT_LSB +: 2];
  assign order = ctrl_q[staging_pkg::CTRL_ORDER_LSB +: 2];
  assign sel1 = sel_q[5:0] == staging_pkg::STAGING_CODE;
  assign sel2 = sel_q[staging_pkg::RELAY_TWO_LSB +: 6] == staging_pkg::STAGING_CODE;
  // A missing module blocks staging so no motor is promised a dead relay
  assign stage_on = enable && !fault_q;

  // Bus: first cycle latches read data, second cycle completes
  assign waitrequest = (read || write) && !ack_q;

  always_comb begin
    ack_d = (read || write) && !ack_q;
    rdata_d = rdata_q;
    ctrl_d = ctrl_q;
    sel_d = sel_q;
    on_thr_d = on_thr_q;
    off_thr_d = off_thr_q;
    on_dly_d = on_dly_q;
    off_dly_d = off_dly_q;
    step_d = step_q;
    if (read && !ack_q) begin
      unique case (address)
        staging_pkg::CTRL_OFS: rdata_d = ctrl_q;
        staging_pkg::RELAY_SEL_OFS: rdata_d = sel_q;
        staging_pkg::ON_THR_OFS: rdata_d = on_thr_q;
        staging_pkg::OFF_THR_OFS: rdata_d = off_thr_q;
        staging_pkg::ON_DELAY_OFS: rdata_d = on_dly_q;
        staging_pkg::OFF_DELAY_OFS: rdata_d = off_dly_q;
        staging_pkg::REF_STEP_OFS: rdata_d = step_q;
        staging_pkg::STATUS_OFS: rdata_d = status;
        staging_pkg::FREQ_OFS: rdata_d = {24'h000000, drive_freq};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    if (write && ack_q) begin
      unique case (address)
        staging_pkg::CTRL_OFS: ctrl_d = merge(ctrl_q, writedata, byteenable) & 32'h0000_003f;
        staging_pkg::RELAY_SEL_OFS: sel_d = merge(sel_q, writedata, byteenable) & 32'h0000_3f3f;
        staging_pkg::ON_THR_OFS: on_thr_d = merge(on_thr_q, writedata, byteenable) & 32'h00ff_ffff;
        staging_pkg::OFF_THR_OFS: off_thr_d = merge(off_thr_q, writedata, byteenable) & 32'h00ff_ffff;
        staging_pkg::ON_DELAY_OFS: on_dly_d = merge(on_dly_q, writedata, byteenable) & 32'h0000_ffff;
        staging_pkg::OFF_DELAY_OFS: off_dly_d = merge(off_dly_q, writedata, byteenable) & 32'h0000_ffff;
        staging_pkg::REF_STEP_OFS: step_d = merge(step_q, writedata, byteenable) & 32'h00ff_ffff;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      ctrl_q <= staging_pkg::CTRL_RESET;
      sel_q <= staging_pkg::RELAY_SEL_RESET;
      on_thr_q <= staging_pkg::ON_THR_RESET;
      off_thr_q <= staging_pkg::OFF_THR_RESET;
      on_dly_q <= staging_pkg::DELAY_RESET;
      off_dly_q <= staging_pkg::DELAY_RESET;
      step_q <= staging_pkg::REF_STEP_RESET;
    end else begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
      sel_q <= sel_d;
      on_thr_q <= on_thr_d;
      off_thr_q <= off_thr_d;
      on_dly_q <= on_dly_d;
      off_dly_q <= off_dly_d;
      step_q <= step_d;
    end
  end

  assign readdata = rdata_q;
  assign status = {delay_q, exp_q, 2'b00, relay2_q, relay1_q, 3'b000, fault_q,
                   state_q == staging_pkg::OFF_WAIT, state_q == staging_pkg::ON_WAIT, running_q};

  // Threshold selection and hysteresis compares
  assign dn_idx = running_q - 2'd1;
  assign up_on = on_thr_q[8*running_q +: 8];
  assign up_off = off_thr_q[8*running_q +: 8];
  assign dn_on = on_thr_q[8*dn_idx +: 8];
  assign dn_off = off_thr_q[8*dn_idx +: 8];
  assign freq9 = {1'b0, drive_freq};
  assign above_arm = freq9 > {1'b0, up_on} + staging_pkg::HYST_HZ;
  assign above_keep = freq9 + staging_pkg::HYST_HZ > {1'b0, up_on};
  assign below_arm = freq9 + staging_pkg::HYST_HZ < {1'b0, dn_off};
  assign below_keep = freq9 < {1'b0, dn_off} + staging_pkg::HYST_HZ;
  assign tick = tick_q == 16'(TICK_CYCLES - 1);

  always_comb begin
    tick_d = tick ? 16'h0000 : tick_q + 16'h0001;
    state_d = state_q;
    running_d = running_q;
    delay_d = delay_q;
    shift_d = shift_q;
    shift_valid_d = 1'b0;
    if (!stage_on) begin
      running_d = 2'd0;
      state_d = staging_pkg::IDLE;
      delay_d = 16'h0000;
    end else if (running_q > count_cfg) begin
      running_d = count_cfg;
      state_d = staging_pkg::IDLE;
      delay_d = 16'h0000;
    end else begin
      unique case (state_q)
        staging_pkg::IDLE: begin
          delay_d = 16'h0000;
          if (running_q < count_cfg && above_arm) begin
            state_d = staging_pkg::ON_WAIT;
          end else if (running_q != 2'd0 && below_arm) begin
            state_d = staging_pkg::OFF_WAIT;
          end
        end
        staging_pkg::ON_WAIT: begin
          if (tick && delay_q < on_dly_q[15:0]) begin
            delay_d = delay_q + 16'h0001;
          end
          if (delay_q >= on_dly_q[15:0]) begin
            state_d = staging_pkg::IDLE;
            delay_d = 16'h0000;
            if (above_keep && running_q < count_cfg) begin
              running_d = running_q + 2'd1;
              shift_d = 9'sd0 - ($signed({1'b0, up_on}) - $signed({1'b0, up_off}));
              shift_valid_d = 1'b1;
            end
          end
        end
        staging_pkg::OFF_WAIT: begin
          if (tick && delay_q < off_dly_q[15:0]) begin
            delay_d = delay_q + 16'h0001;
          end
          if (delay_q >= off_dly_q[15:0]) begin
            state_d = staging_pkg::IDLE;
            delay_d = 16'h0000;
            if (below_keep) begin
              running_d = running_q - 2'd1;
              shift_d = $signed({1'b0, dn_on}) - $signed({1'b0, dn_off});
              shift_valid_d = 1'b1;
            end
          end
        end
        default: state_d = staging_pkg::IDLE;
      endcase
    end
    ref_d = 10'h000;
    if (running_d >= 2'd1) begin
      ref_d = ref_d + {2'b00, step_q[7:0]};
    end
    if (running_d >= 2'd2) begin
      ref_d = ref_d + {2'b00, step_q[15:8]};
    end
    if (running_d == 2'd3) begin
      ref_d = ref_d + {2'b00, step_q[23:16]};
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tick_q <= 16'h0000;
      state_q <= staging_pkg::IDLE;
      running_q <= 2'd0;
      delay_q <= 16'h0000;
      shift_q <= 9'sd0;
      shift_valid_q <= 1'b0;
      ref_q <= 10'h000;
    end else begin
      tick_q <= tick_d;
      state_q <= state_d;
      running_q <= running_d;
      delay_q <= delay_d;
      shift_q <= shift_d;
      shift_valid_q <= shift_valid_d;
      ref_q <= ref_d;
    end
  end

  assign freq_shift = shift_q;
  assign freq_shift_valid = shift_valid_q;
  assign ref_step_total = ref_q;

  // Relay mapping: motor slots fill builtin relays first, then modules
  always_comb begin
    int motors;
    int base;
    int m;
    int l;
    m = 0;
    l = 0;
    motors = int'(count_cfg) + 1;
    base = int'(sel1) + int'(sel2);
    logical_on = 4'h0;
    phys_on = 4'h0;
    for (int i = 0; i < 4; i++) begin
      logical_on[i] = enable && (i == 0 || int'(running_q) >= i);
    end
    for (int i = 0; i < 4; i++) begin
      l = rotate ? (i + motors - (int'(order) % motors)) % motors : i;
      if (i < motors) begin
        phys_on[i] = logical_on[2'(l)];
      end
    end
    relay1_d = sel1 ? phys_on[0] : relay_one_other;
    relay2_d = sel2 ? phys_on[sel1 ? 1 : 0] : relay_two_other;
    for (int p = 0; p < 4; p++) begin
      m = base + p;
      exp_d[p] = (m < motors) ? phys_on[2'(m)] : 1'b0;
    end
    fault_now = (motors - base > 0 && !expansion_present[0]) ||
                (motors - base > 2 && !expansion_present[1]);
    fault_d = enable && fault_now;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      relay1_q <= 1'b0;
      relay2_q <= 1'b0;
      exp_q <= 4'h0;
      fault_q <= 1'b0;
    end else begin
      relay1_q <= relay1_d;
      relay2_q <= relay2_d;
      exp_q <= exp_d;
      fault_q <= fault_d;
    end
  end

  assign builtin_relay_one = relay1_q;
  assign builtin_relay_two = relay2_q;
  assign expansion_relay = exp_q;
  assign expansion_link_fault = fault_q;

  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  bus_one_wait_a: assert property ($rose(read) |-> waitrequest ##1 !waitrequest)
    else $error("read not answered after one wait");
  step_sum_a: assert property (running_q == 2'd3 |->
      ref_q == {2'b00, step_q[7:0]} + {2'b00, step_q[15:8]} + {2'b00, step_q[23:16]})
    else $error("reference step sum wrong for three motors");
  start_arm_a: assert property (state_q == staging_pkg::IDLE && stage_on &&
      running_q < count_cfg && freq9 > {1'b0, up_on} + 9'h001 |=>
      state_q == staging_pkg::ON_WAIT)
    else $error("start delay not armed");
  start_delay_a: assert property ($rose(running_q != 2'd0) |->
      $past(state_q) == staging_pkg::ON_WAIT && $past(delay_q) >= $past(on_dly_q[15:0]))
    else $error("motor started before delay");
  start_shift_a: assert property (running_q != 2'd0 && running_q == $past(running_q) + 2'd1 &&
      $past(stage_on) |->
      freq_shift_valid && freq_shift < 9'sd1)
    else $error("no downward shift on start");
  stop_shift_a: assert property (freq_shift_valid && $past(state_q) == staging_pkg::OFF_WAIT |->
      running_q == $past(running_q) - 2'd1 && freq_shift > -9'sd1)
    else $error("stop shift wrong");
  count_limit_a: assert property (running_q > count_cfg |=> running_q <= $past(count_cfg))
    else $error("running count above configured count");
  cancel_wait_a: assert property (running_q != $past(running_q) |-> state_q == staging_pkg::IDLE)
    else $error("delay survived a count change");
  relay_one_a: assert property (sel1 && !rotate && enable ##1 sel1 && !rotate && enable |->
      builtin_relay_one)
    else $error("regulated motor relay not driven");
  link_fault_a: assert property (enable && count_cfg == 2'd3 && !sel1 && !sel2 &&
      !expansion_present[1] |=> expansion_link_fault)
    else $error("missing module not flagged");
  write_one_wait_a: assert property ($rose(write) |-> waitrequest ##1 !waitrequest)
    else $error("write not answered after one wait");
  stop_arm_a: assert property (state_q == staging_pkg::IDLE && stage_on &&
      running_q != 2'd0 && running_q == count_cfg &&
      freq9 + 9'h001 < {1'b0, dn_off} |=> state_q == staging_pkg::OFF_WAIT)
    else $error("stop delay not armed");
  stop_delay_a: assert property (freq_shift_valid && $past(state_q) == staging_pkg::OFF_WAIT |->
      $past(delay_q) >= $past(off_dly_q[15:0]))
    else $error("motor stopped before delay");
  ref_one_a: assert property (running_q == 2'd1 |->
      ref_q == {2'b00, step_q[7:0]})
    else $error("reference step wrong for one motor");
  ref_two_a: assert property (running_q == 2'd2 |->
      ref_q == {2'b00, step_q[7:0]} + {2'b00, step_q[15:8]})
    else $error("reference step sum wrong for two motors");
  other_two_a: assert property (!sel2 |=>
      builtin_relay_two == $past(relay_two_other))
    else $error("relay two lost its other function");
endmodule // pump_fan_staging

// file: contactor_bank.sv
// Purpose: Far-side model: relay-driven contactors and expansion relay modules.
// Assumes: Relay drives are level; a contactor pulls in one cycle after its coil.
// Notes: A module that is not fitted reports absent and ignores its coil drives.
`timescale 1ns/1ps
module contactor_bank (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic builtin_relay_one,
  input wire logic builtin_relay_two,
  input wire logic [3:0] expansion_relay,
  input wire logic node5_fitted,
  input wire logic node6_fitted,
  output logic [1:0] expansion_present,
  output logic [5:0] motor_run_q
);
  logic [5:0] motor_run_d;
  // Presence follows the bench's fitting choice
  assign expansion_present = {node6_fitted, node5_fitted};
  always_comb begin
    // Coils on a missing module cannot close anything
    motor_run_d = {expansion_relay[3:2] & {2{node6_fitted}},
                   expansion_relay[1:0] & {2{node5_fitted}},
                   builtin_relay_two, builtin_relay_one};
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      motor_run_q <= 6'h00;
    end else begin
      motor_run_q <= motor_run_d;
    end
  end
endmodule // contactor_bank

// file: tb_pump_fan_staging.sv
// Purpose: Self-checking bench for the helper motor staging controller.
// Assumes: One ms tick is shortened to 4 clocks; delays are set in ms.
// Notes: The bus is sampled at the rising edge, before that edge's updates land.
`timescale 1ns/1ps
module tb_pump_fan_staging;
  localparam int TICK = 4;
  logic clock, reset_n, read, write, relay_one_other, relay_two_other;
  logic node5_fitted, node6_fitted, waitrequest, builtin_relay_one, builtin_relay_two;
  logic freq_shift_valid, expansion_link_fault;
  logic [5:0] address;
  logic [31:0] writedata, readdata, rd;
  logic [3:0] byteenable, expansion_relay;
  logic [7:0] drive_freq;
  logic [1:0] expansion_present;
  logic signed [8:0] freq_shift;
  logic [9:0] ref_step_total;
  logic [5:0] motor_run_q;
  int error_cnt = 0;
  int n_compared = 0;

  pump_fan_staging #(.TICK_CYCLES(TICK)) uut (.clock(clock), .reset_n(reset_n),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .drive_freq(drive_freq), .expansion_present(expansion_present),
    .relay_one_other(relay_one_other), .relay_two_other(relay_two_other),
    .builtin_relay_one(builtin_relay_one), .builtin_relay_two(builtin_relay_two),
    .expansion_relay(expansion_relay), .freq_shift(freq_shift),
    .freq_shift_valid(freq_shift_valid), .ref_step_total(ref_step_total),
    .expansion_link_fault(expansion_link_fault));
  contactor_bank far (.clock(clock), .reset_n(reset_n),
    .builtin_relay_one(builtin_relay_one), .builtin_relay_two(builtin_relay_two),
    .expansion_relay(expansion_relay), .node5_fitted(node5_fitted),
    .node6_fitted(node6_fitted), .expansion_present(expansion_present),
    .motor_run_q(motor_run_q));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic give_verdict();
    if (error_cnt == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Request held until waitrequest is seen low; released after that edge
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    address <= a;
    writedata <= d;
    byteenable <= 4'hf;
    if (wr) write <= 1'b1;
    else read <= 1'b1;
    @(posedge clock);
    while (waitrequest !== 1'b0 && n < 50) begin
      @(posedge clock);
      n++;
    end
    if (n >= 50) check("waitrequest", {31'h0, waitrequest}, 32'h0);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clock);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Waits for one frequency step and checks its size and the delay before it
  task automatic expect_step(input logic [31:0] shift, input int min_cyc, input int max_cyc);
    int n;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (freq_shift_valid !== 1'b1 && n < max_cyc);
    check("shift_seen", {31'h0, freq_shift_valid}, 32'h1);
    check("freq_shift", 32'(freq_shift), shift);
    check("delay_ok", {31'h0, n >= min_cyc}, 32'h1);
    @(posedge clock);
    idle(2);
  endtask

  task automatic expect_running(input logic [31:0] cnt, input logic [31:0] steps);
    bus(1'b0, staging_pkg::STATUS_OFS, 32'h0);
    check("running", {30'h0, rd[1:0]}, cnt);
    check("ref_step_total", {22'h0, ref_step_total}, steps);
  endtask

  task automatic reset_values();
    bus(1'b0, staging_pkg::CTRL_OFS, 32'h0);
    check("ctrl", rd, 32'h0);
    bus(1'b0, staging_pkg::RELAY_SEL_OFS, 32'h0);
    check("relay_sel", rd, 32'h0000_1d1d);
    bus(1'b0, staging_pkg::ON_THR_OFS, 32'h0);
    check("on_thr", rd, 32'h0030_3030);
    bus(1'b0, staging_pkg::OFF_THR_OFS, 32'h0);
    check("off_thr", rd, 32'h0019_1919);
    bus(1'b0, staging_pkg::ON_DELAY_OFS, 32'h0);
    check("on_delay", rd, 32'h0000_0bb8);
    bus(1'b0, staging_pkg::REF_STEP_OFS, 32'h0);
    check("ref_steps", rd, 32'h0);
    bus(1'b0, 6'h3c, 32'h0);
    check("unmapped", rd, 32'h0);
  endtask

  task automatic stage_up();
    bus(1'b1, staging_pkg::ON_THR_OFS, 32'h0032_2d28);
    bus(1'b1, staging_pkg::OFF_THR_OFS, 32'h0018_1614);
    bus(1'b1, staging_pkg::ON_DELAY_OFS, 32'h2);
    bus(1'b1, staging_pkg::OFF_DELAY_OFS, 32'h3);
    bus(1'b1, staging_pkg::REF_STEP_OFS, 32'h0009_0705);
    bus(1'b1, staging_pkg::CTRL_OFS, 32'h0000_000d);
    drive_freq <= 8'd41;
    idle(40);
    expect_running(0, 0);
    check("regulated", {31'h0, builtin_relay_one}, 32'h1);
    drive_freq <= 8'd42;
    expect_step(-20, 2 * TICK, 200);
    expect_running(1, 5);
    check("motor2", {31'h0, builtin_relay_two}, 32'h1);
    drive_freq <= 8'd47;
    idle(2);
    drive_freq <= 8'd44;
    idle(40);
    expect_running(1, 5);
    drive_freq <= 8'd47;
    idle(2);
    drive_freq <= 8'd45;
    // The delay was armed two clocks before this wait begins
    expect_step(-23, 2 * TICK - 2, 200);
    expect_running(2, 12);
    drive_freq <= 8'd52;
    expect_step(-26, 2 * TICK, 200);
    expect_running(3, 21);
    check("exp_relays", {28'h0, expansion_relay}, 32'h3);
    check("contactors", {26'h0, motor_run_q}, 32'h0f);
    drive_freq <= 8'd60;
    idle(60);
    expect_running(3, 21);
  endtask

  task automatic stage_down();
    drive_freq <= 8'd22;
    expect_step(26, 3 * TICK, 200);
    expect_running(2, 12);
    drive_freq <= 8'd20;
    expect_step(23, 3 * TICK, 200);
    expect_running(1, 5);
    drive_freq <= 8'd18;
    expect_step(20, 3 * TICK, 200);
    expect_running(0, 0);
    check("motor2_off", {31'h0, builtin_relay_two}, 32'h0);
  endtask

  task automatic fault_and_relays();
    node5_fitted <= 1'b0;
    idle(4);
    check("link_fault", {31'h0, expansion_link_fault}, 32'h1);
    node5_fitted <= 1'b1;
    bus(1'b1, staging_pkg::RELAY_SEL_OFS, 32'h0000_1d00);
    idle(4);
    check("link_fault6", {31'h0, expansion_link_fault}, 32'h1);
    bus(1'b1, staging_pkg::CTRL_OFS, 32'h0000_0005);
    relay_one_other <= 1'b1;
    idle(4);
    check("no_fault", {31'h0, expansion_link_fault}, 32'h0);
    check("other_fn", {31'h0, builtin_relay_one}, 32'h1);
    relay_one_other <= 1'b0;
    idle(3);
    check("other_fn0", {31'h0, builtin_relay_one}, 32'h0);
    check("regulated2", {31'h0, builtin_relay_two}, 32'h1);
    drive_freq <= 8'd42;
    expect_step(-20, 2 * TICK, 200);
    check("node5_out1", {31'h0, expansion_relay[0]}, 32'h1);
    bus(1'b1, staging_pkg::CTRL_OFS, 32'h0000_0001);
    idle(4);
    expect_running(0, 0);
    // Rotation order one moves the regulated motor onto the node five relay
    drive_freq <= 8'd30;
    bus(1'b1, staging_pkg::CTRL_OFS, 32'h0000_0017);
    idle(3);
    check("rot_relay2", {31'h0, builtin_relay_two}, 32'h0);
    check("rot_node5", {31'h0, expansion_relay[0]}, 32'h1);
    bus(1'b1, staging_pkg::RELAY_SEL_OFS, 32'h0000_0000);
    bus(1'b1, staging_pkg::CTRL_OFS, 32'h0000_000d);
    idle(4);
    check("link_fault_none", {31'h0, expansion_link_fault}, 32'h1);
    check("other_fn_none", {31'h0, builtin_relay_one}, 32'h0);
  endtask

  initial begin
    reset_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 6'h00;
    writedata = 32'h0;
    byteenable = 4'h0;
    drive_freq = 8'h00;
    relay_one_other = 1'b0;
    relay_two_other = 1'b0;
    node5_fitted = 1'b1;
    node6_fitted = 1'b0;
    idle(20);
    reset_n <= 1'b1;
    idle(1);
    reset_values();
    stage_up();
    stage_down();
    fault_and_relays();
    give_verdict();
  end

  // Whole sequence needs a few hundred cycles; this is a wide margin
  initial begin
    idle(20000);
    error_cnt++;
    give_verdict();
  end
endmodule // tb_pump_fan_staging
